// ### rtl/general_timer_unit.sv
/*
  Two-channel general timer with prescaler, auto-reload, single-shot and
  input-capture modes, APB register slave and one interrupt per channel.
  Assumes an APB master on I_CLOCK and asynchronous capture input pins.
*/
// How it works
// - Two independent channels, each: 16-bit counter, 8-bit prescaler.
// - Prescaler divides the clock by a power of two from 1 to 256.
// - Counter advances by one per prescaled tick; software can read it.
// - Match, rise and fall events share one interrupt per channel.
// - Each event source has its own mask bit and its own acknowledge.
// - Each channel has its own registers and runs independently.
// - Modes are auto-reload, single-shot and input capture.
// - Enabling a timer mode clears the counter, then it counts up.
// - Auto-reload: on compare raise match, clear counter, count on.
// - Auto-reload repeats until software disables the channel.
// - Single-shot: on compare raise match, halt counter, clear enable.
// - Capture mode: rising input edge stores counter in rise register.
// - Capture mode: falling input edge stores counter in fall register.
`timescale 1ns/1ns
`default_nettype none

module general_timer_unit #(
  parameter int NUM_CHAN = 2,
  parameter int COUNT_W = 16,
  parameter int PSC_W = 8
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [general_timer_unit_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [NUM_CHAN-1:0] I_CAPTURE,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic [NUM_CHAN-1:0] O_IRQ
);

  // The address decode serves exactly two channel blocks and the divider
  // select reaches two to the eighth, so other sizes are refused.
  if (NUM_CHAN != 2 || PSC_W != 8
      || COUNT_W < 1 || COUNT_W > 32) begin : g_check
    $error("general_timer_unit: unsupported parameter values");
  end

  // Local copy of the event width keeps the struct fields short.
  localparam int EV_W = general_timer_unit_pkg::EV_W;

  // Everything a channel keeps between clock edges.
  typedef struct packed {
    logic enable;
    logic [1:0] mode;
    logic [3:0] div_select;
    logic [COUNT_W-1:0] compare;
    logic [COUNT_W-1:0] count;
    logic [PSC_W-1:0] prescale;
    logic [COUNT_W-1:0] rise_capture;
    logic [COUNT_W-1:0] fall_capture;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
  } chan_t;

  // The whole module state, registered as one word.
  typedef struct packed {
    chan_t [NUM_CHAN-1:0] chan;
    logic [NUM_CHAN-1:0] cap_meta;
    logic [NUM_CHAN-1:0] cap_sync;
    logic [NUM_CHAN-1:0] cap_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_CHAN-1:0] irq;
  } state_t;

  state_t state;
  state_t next_state;

  // Reset value of one channel.
  function automatic chan_t chan_reset();
    chan_t c;
    c = '0;
    c.mode = general_timer_unit_pkg::RESET_MODE;
    c.div_select = general_timer_unit_pkg::RESET_DIV;
    c.compare = COUNT_W'(general_timer_unit_pkg::RESET_COMPARE);
    c.mask = general_timer_unit_pkg::RESET_MASK;
    return c;
  endfunction

  // Decoded fields of the current APB request.
  logic sel_chan;
  logic [4:0] reg_ofs;
  logic addr_hit;
  logic access_done;

  // The channel is chosen by one address bit; the upper bits must be zero
  // and reserved offsets inside a block miss.
  always_comb begin
    sel_chan = I_PADDR[general_timer_unit_pkg::CHAN_STRIDE_BIT];
    reg_ofs = {I_PADDR[4:2], 2'h0};
    addr_hit = (I_PADDR[general_timer_unit_pkg::ADDR_W-1:6] == '0)
      && (I_PADDR[1:0] == 2'h0)
      && (reg_ofs <= general_timer_unit_pkg::OFS_EVENT_MASK);
    access_done = I_PSEL && I_PENABLE && state.pready;
  end

  // Read value of the addressed register, taken at the setup cycle.
  function automatic logic [31:0] read_reg(chan_t c, logic [4:0] ofs);
    logic [31:0] v;
    v = '0;
    case (ofs)
      general_timer_unit_pkg::OFS_CONTROL: begin
        v[general_timer_unit_pkg::CTRL_ENABLE_BIT] = c.enable;
        v[general_timer_unit_pkg::CTRL_MODE_LSB +: 2] = c.mode;
        v[general_timer_unit_pkg::CTRL_DIV_LSB +: 4] = c.div_select;
      end
      general_timer_unit_pkg::OFS_COMPARE: v[COUNT_W-1:0] = c.compare;
      general_timer_unit_pkg::OFS_COUNT: v[COUNT_W-1:0] = c.count;
      general_timer_unit_pkg::OFS_RISE_CAPTURE:
        v[COUNT_W-1:0] = c.rise_capture;
      general_timer_unit_pkg::OFS_FALL_CAPTURE:
        v[COUNT_W-1:0] = c.fall_capture;
      general_timer_unit_pkg::OFS_EVENT_STATUS: v[EV_W-1:0] = c.status;
      general_timer_unit_pkg::OFS_EVENT_MASK: v[EV_W-1:0] = c.mask;
      default: v = '0;
    endcase
    return v;
  endfunction

  // Next-state logic: bus slave, synchronisers and both channels.
  always_comb begin
    logic [PSC_W-1:0] div_mask;
    logic tick;
    logic wr;
    logic rd;
    logic rise;
    logic fall;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] ack;
    logic [3:0] div_in;
    div_mask = '0;
    tick = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    ev = '0;
    ack = '0;
    div_in = '0;
    next_state = state;

    // Two flip-flops in series; only the second stage feeds edge detection.
    // The extra cycles of latency are the price of a safe capture path.
    next_state.cap_meta = I_CAPTURE;
    next_state.cap_sync = state.cap_meta;
    next_state.cap_prev = state.cap_sync;

    // No wait states: the answer is prepared at the setup edge, so the
    // access phase always completes on its first cycle.
    next_state.pready = 1'b0;
    next_state.pslverr = 1'b0;
    if (I_PSEL && !I_PENABLE && !state.pready) begin
      next_state.pready = 1'b1;
      next_state.pslverr = !addr_hit;
      next_state.prdata = addr_hit ? read_reg(state.chan[sel_chan], reg_ofs)
        : 32'h0000_0000;
    end

    for (int c = 0; c < NUM_CHAN; c++) begin
      // Side effects belong to the access edge only, never to setup.
      wr = access_done && I_PWRITE && addr_hit
        && (sel_chan == c[0]);
      rd = access_done && !I_PWRITE && addr_hit && (sel_chan == c[0]);
      ev = '0;
      ack = '0;

      // Prescaler: tick when the low select bits of the running count are
      // all ones, giving a divide by two to the power of the select.
      div_mask = ~({PSC_W{1'b1}} << state.chan[c].div_select);
      // A select of eight masks all bits, so one tick takes 256 cycles.
      tick = (state.chan[c].prescale & div_mask) == div_mask;
      if (state.chan[c].enable) begin
        next_state.chan[c].prescale = state.chan[c].prescale + 1'b1;
        if (tick) begin
          case (state.chan[c].mode)
            general_timer_unit_pkg::MODE_AUTO_RELOAD: begin
              if (state.chan[c].count == state.chan[c].compare) begin
                ev[general_timer_unit_pkg::EV_MATCH_BIT] = 1'b1;
                next_state.chan[c].count = '0;
              end else begin
                next_state.chan[c].count =
                  state.chan[c].count + 1'b1;
              end
            end
            // The count rests on the compare value after the shot.
            general_timer_unit_pkg::MODE_SINGLE_SHOT: begin
              if (state.chan[c].count == state.chan[c].compare) begin
                ev[general_timer_unit_pkg::EV_MATCH_BIT] = 1'b1;
                next_state.chan[c].enable = 1'b0;
              end else begin
                next_state.chan[c].count =
                  state.chan[c].count + 1'b1;
              end
            end
            general_timer_unit_pkg::MODE_CAPTURE: begin
              // Free-running time base; wraps at full scale.
              // Software must allow for one wrap when subtracting captures.
              next_state.chan[c].count = state.chan[c].count + 1'b1;
            end
            // Mode three is idle: the counter holds its value.
            default: next_state.chan[c].count = state.chan[c].count;
          endcase
        end
      end

      // Edges are taken from the synchronised level against its history.
      rise = state.cap_sync[c] && !state.cap_prev[c];
      fall = !state.cap_sync[c] && state.cap_prev[c];
      if (state.chan[c].enable
          && state.chan[c].mode == general_timer_unit_pkg::MODE_CAPTURE) begin
        if (rise) begin
          next_state.chan[c].rise_capture = state.chan[c].count;
          ev[general_timer_unit_pkg::EV_RISE_BIT] = 1'b1;
        end
        if (fall) begin
          next_state.chan[c].fall_capture = state.chan[c].count;
          ev[general_timer_unit_pkg::EV_FALL_BIT] = 1'b1;
        end
      end

      // Register writes. A software write lands after the hardware update,
      // so a disable issued in the same cycle as a match still wins.
      if (wr) begin
        case (reg_ofs)
          general_timer_unit_pkg::OFS_CONTROL: begin
            div_in = I_PWDATA[general_timer_unit_pkg::CTRL_DIV_LSB +: 4];
            next_state.chan[c].mode =
              I_PWDATA[general_timer_unit_pkg::CTRL_MODE_LSB +: 2];
            next_state.chan[c].div_select =
              (div_in > general_timer_unit_pkg::MAX_DIV_SELECT)
              ? general_timer_unit_pkg::MAX_DIV_SELECT : div_in;
            next_state.chan[c].enable =
              I_PWDATA[general_timer_unit_pkg::CTRL_ENABLE_BIT];
            if (I_PWDATA[general_timer_unit_pkg::CTRL_ENABLE_BIT]
                && !state.chan[c].enable) begin
              next_state.chan[c].count = '0;
              next_state.chan[c].prescale = '0;
            end
          end
          general_timer_unit_pkg::OFS_COMPARE:
            next_state.chan[c].compare = I_PWDATA[COUNT_W-1:0];
          general_timer_unit_pkg::OFS_EVENT_STATUS:
            ack = I_PWDATA[EV_W-1:0];
          general_timer_unit_pkg::OFS_EVENT_MASK:
            next_state.chan[c].mask = I_PWDATA[EV_W-1:0];
          default: ack = '0;
        endcase
      end

      // A status read acknowledges only the bits it returned, so an event
      // arriving between setup and completion is not lost.
      if (rd && reg_ofs == general_timer_unit_pkg::OFS_EVENT_STATUS) begin
        ack = state.prdata[EV_W-1:0];
      end

      // Sticky flags; a new event wins over a same-cycle acknowledge.
      next_state.chan[c].status =
        (state.chan[c].status & ~ack) | ev;
      // The pin follows the next flags, so it rises with the flag itself.
      next_state.irq[c] =
        |(next_state.chan[c].status & next_state.chan[c].mask);
    end
  end

  // Single state register with synchronous reset. Channel fields that
  // reset to non-zero values are overlaid after the blanket clear.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      state <= '0;
      for (int c = 0; c < NUM_CHAN; c++) begin
        state.chan[c] <= chan_reset();
      end
    end else begin
      state <= next_state;
    end
  end

  // Every output is a flip-flop of the state word, so no bus or interrupt
  // pin ever shows a combinational glitch.
  assign O_PRDATA = state.prdata;
  assign O_PREADY = state.pready;
  assign O_PSLVERR = state.pslverr;
  assign O_IRQ = state.irq;

endmodule

`default_nettype wire

// ### shared/general_timer_unit_pkg.sv
/*
  Constants shared by the two-channel timer with input capture: register
  offsets, field positions, reset values and mode encodings.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package general_timer_unit_pkg;

  // Byte address layout: one register block per channel.
  localparam int ADDR_W = 12;
  localparam int CHAN_STRIDE_BIT = 5;
  localparam int REG_INDEX_LSB = 2;
  localparam int REG_INDEX_W = 3;

  // Register offsets inside a channel block.
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_COMPARE = 5'h04;
  localparam logic [4:0] OFS_COUNT = 5'h08;
  localparam logic [4:0] OFS_RISE_CAPTURE = 5'h0c;
  localparam logic [4:0] OFS_FALL_CAPTURE = 5'h10;
  localparam logic [4:0] OFS_EVENT_STATUS = 5'h14;
  localparam logic [4:0] OFS_EVENT_MASK = 5'h18;

  // Control register fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_W = 2;
  localparam int CTRL_DIV_LSB = 4;
  localparam int CTRL_DIV_W = 4;

  // Operating modes held in the control mode field.
  localparam logic [1:0] MODE_AUTO_RELOAD = 2'h0;
  localparam logic [1:0] MODE_SINGLE_SHOT = 2'h1;
  localparam logic [1:0] MODE_CAPTURE = 2'h2;

  // Event bits, common to status and mask registers.
  localparam int EV_W = 3;
  localparam int EV_MATCH_BIT = 0;
  localparam int EV_RISE_BIT = 1;
  localparam int EV_FALL_BIT = 2;

  // Reset values.
  localparam logic [1:0] RESET_MODE = MODE_AUTO_RELOAD;
  localparam logic [3:0] RESET_DIV = 4'h0;
  localparam logic [15:0] RESET_COMPARE = 16'hffff;
  localparam logic [2:0] RESET_MASK = 3'h0;

  // Largest divider select: a divide ratio of two to this power.
  localparam logic [3:0] MAX_DIV_SELECT = 4'h8;

endpackage

// ### dv/capture_source.sv
/* Model of the outside signal source on the capture pins.
   Assumes one bench process calls its task at a time. */
`timescale 1ns/1ns
`default_nettype none
module capture_source #(
  parameter int NUM_CHAN = 2
) (
  input wire logic i_clock,
  output logic [NUM_CHAN-1:0] o_level
);
  // Pins idle low; a change lands just after an edge.
  initial o_level = '0;
  task automatic drive(input int ch, input logic v);
    @(posedge i_clock);
    o_level[ch] <= v;
  endtask
endmodule
`default_nettype wire

// ### dv/general_timer_unit_props.sv
/* Checker for the bus handshake and interrupt pins of the timer.
   Sees only the top module's ports; bound in below. */
`timescale 1ns/1ns
`default_nettype none
module general_timer_unit_checker #(
  parameter int NUM_CHAN = 2
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic [general_timer_unit_pkg::ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [NUM_CHAN-1:0] O_IRQ
);
  // One clock domain; reset cancels every attempt but the interrupt-after-reset check.
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  // The slave never stalls, so a sticking ready means a hung handshake.
  ready_after_setup_a: assert property (
    I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready missing after setup");
  ready_one_cycle_a: assert property (
    O_PREADY |=> !O_PREADY)
    else $error("ready held too long");
  ready_in_access_a: assert property (
    O_PREADY |-> I_PSEL && I_PENABLE)
    else $error("ready outside access");
  error_zero_data_a: assert property (
    O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
    else $error("bad error response");
  unmapped_error_a: assert property (
    I_PSEL && !I_PENABLE && I_PADDR[11:6] != 6'h0 |=> O_PSLVERR)
    else $error("unmapped access accepted");
  mapped_no_error_a: assert property (
    I_PSEL && !I_PENABLE && I_PADDR[11:6] == 6'h0
    && I_PADDR[1:0] == 2'h0 && I_PADDR[4:0] <= 5'h18 |=> !O_PSLVERR)
    else $error("mapped access refused");
  // Read data is only reloaded by a setup cycle, so it holds otherwise.
  read_data_hold_a: assert property (
    !(I_PSEL && !I_PENABLE) |=> $stable(O_PRDATA))
    else $error("read data changed outside setup");
  // Without bus traffic nothing can acknowledge a flag.
  irq_sticky_a: assert property (
    !I_PSEL |=> (O_IRQ & $past(O_IRQ)) == $past(O_IRQ))
    else $error("interrupt dropped without access");
  irq_reset_low_a: assert property (
    disable iff (1'b0) I_RESET |=> O_IRQ == '0)
    else $error("interrupt high after reset");
endmodule
bind general_timer_unit general_timer_unit_checker #(.NUM_CHAN(NUM_CHAN)) chk (
  .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ));
`default_nettype wire

// ### dv/general_timer_unit_tb.sv
/* Self-checking bench: register defaults, prescaled periods,
   single-shot stop and input capture. Assumes the source model. */
`timescale 1ns/1ns
`default_nettype none
module general_timer_unit_tb;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic e;
  } row_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic [1:0] irq;
  logic [1:0] cap;
  logic [15:0] rise;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  // Defaults of both channels, then two unmapped places.
  row_t rows [8] = '{'{12'h000, 32'h0, 1'b0}, '{12'h004, 32'hffff, 1'b0},
    '{12'h008, 32'h0, 1'b0}, '{12'h00c, 32'h0, 1'b0},
    '{12'h018, 32'h0, 1'b0}, '{12'h024, 32'hffff, 1'b0},
    '{12'h01c, 32'h0, 1'b1}, '{12'h040, 32'h0, 1'b1}};
  always #25 clock = ~clock;
  general_timer_unit uut (.I_CLOCK(clock), .I_RESET(reset), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_CAPTURE(cap), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq));
  capture_source src (.i_clock(clock), .o_level(cap));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // One transfer; the request stands until ready is sampled high.
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts edges until the channel interrupt is seen high.
  task automatic wait_irq(input int c);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (irq[c] !== 1'b1);
  endtask
  // A hang is cut short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    chk("irq", 32'h0, {30'h0, irq});
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk("data", rows[i].d, rd);
      chk("error", {31'h0, rows[i].e}, {31'h0, err});
    end
    // A write to an unmapped place is refused with an error.
    bus(1'b1, 12'h040, 32'h1);
    chk("werr", 32'h1, {31'h0, err});
    // Every divider with compare 1: match after two ticks.
    bus(1'b1, 12'h004, 32'h1);
    bus(1'b1, 12'h018, 32'h1);
    for (int s = 0; s <= 8; s++) begin
      bus(1'b1, 12'h000, {24'h0, 4'(s), 4'h1});
      wait_irq(0);
      chk("period", 32'((2 << s) + 1), n);
      bus(1'b0, 12'h014, 32'h0);
      chk("match", 32'h1, rd);
      wait_irq(0);
      chk("again", 32'h1, {31'h0, n <= (2 << s)});
      bus(1'b1, 12'h000, 32'h0);
      bus(1'b0, 12'h014, 32'h0);
    end
    // Single shot stops on the compare value and drops its enable.
    bus(1'b1, 12'h004, 32'h3);
    bus(1'b1, 12'h000, 32'h3);
    wait_irq(0);
    chk("start", 32'h5, n);
    repeat (4) @(posedge clock);
    bus(1'b0, 12'h008, 32'h0);
    chk("held", 32'h3, rd);
    bus(1'b0, 12'h000, 32'h0);
    chk("enable", 32'h2, rd);
    // Writing a one to the match flag acknowledges it and drops the pin.
    chk("pending", 32'h1, {31'h0, irq[0]});
    bus(1'b1, 12'h014, 32'h1);
    @(posedge clock);
    chk("ack", 32'h0, {31'h0, irq[0]});
    // Mode 3 holds the count; a select above eight is kept at eight.
    bus(1'b1, 12'h000, 32'hf6);
    bus(1'b0, 12'h000, 32'h0);
    chk("clamp", 32'h86, rd);
    bus(1'b1, 12'h000, 32'h7);
    bus(1'b1, 12'h008, 32'h5);
    bus(1'b0, 12'h008, 32'h0);
    chk("idle", 32'h0, rd);
    bus(1'b1, 12'h000, 32'h0);
    // Capture on channel 1; the fall is masked off the interrupt.
    bus(1'b1, 12'h038, 32'h7);
    bus(1'b1, 12'h020, 32'h5);
    src.drive(1, 1'b1);
    wait_irq(1);
    chk("sync", 32'h4, n);
    bus(1'b0, 12'h034, 32'h0);
    chk("rise", 32'h2, rd);
    bus(1'b1, 12'h038, 32'h3);
    repeat (7) @(posedge clock);
    src.drive(1, 1'b0);
    repeat (6) @(posedge clock);
    chk("masked", 32'h0, {31'h0, irq[1]});
    bus(1'b0, 12'h034, 32'h0);
    chk("fall", 32'h4, rd);
    bus(1'b0, 12'h02c, 32'h0);
    rise = rd[15:0];
    bus(1'b0, 12'h030, 32'h0);
    chk("width", 32'd18, {16'h0, rd[15:0] - rise});
    // A reset in mid-run returns the channels to their defaults.
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk("reset irq", 32'h0, {30'h0, irq});
    bus(1'b0, 12'h02c, 32'h0);
    chk("reset capture", 32'h0, rd);
    wrap_up();
  end
endmodule
`default_nettype wire
